// ---- src/cmob_bank.sv ----
// message object enable, interrupt mask and completion flag bank
`timescale 1ns/1ps
`include "cmob_defines.svh"

module cmob_bank #(
	parameter int NUM_OBJ = 32
) (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire cmob_pkg::cmob_events_t done_evt,
	output logic      [NUM_OBJ-1:0]    obj_enabled,
	output logic      [NUM_OBJ-1:0]    per_object_rx_done,
	output logic      [NUM_OBJ-1:0]    per_object_tx_done,
	output logic                       irq
);

	// ****************************************
	// functions
	// ****************************************

	// set wins over clear so that an event in the clearing cycle survives
	function automatic logic [NUM_OBJ-1:0] upd(
		input logic [NUM_OBJ-1:0] cur,
		input logic [NUM_OBJ-1:0] set,
		input logic [NUM_OBJ-1:0] clr
	);
		upd = (cur & ~clr) | set;
	endfunction : upd

	// widen an object vector to a bus word, upper bits zero
	function automatic logic [31:0] to_word(
		input logic [NUM_OBJ-1:0] v
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[NUM_OBJ-1:0] = v;
		to_word = w;
	endfunction : to_word

	// ****************************************
	// bus address phase capture
	// ****************************************
	cmob_pkg::cmob_addr_phase_t ap;
	cmob_pkg::cmob_addr_phase_t next_ap;

	wire logic take_phase;
	wire logic wr_active;
	wire logic [7:0] wa;
	wire logic [NUM_OBJ-1:0] wbits;

	// only single word transfers are sent, so hsize is not decoded
	assign take_phase = hsel & hready &
		((htrans == `CMOB_HTRANS_NONSEQ) | (htrans == `CMOB_HTRANS_SEQ));
	// one driver for the whole captured phase
	assign next_ap = '{valid: take_phase, write: hwrite, addr: haddr[7:0]};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ap <= '0;
		else if (hready)
			ap <= next_ap;
	end

	assign wr_active = ap.valid & ap.write;
	assign wa        = ap.addr;
	assign wbits     = hwdata[NUM_OBJ-1:0];

	// ****************************************
	// write strobe decode
	// ****************************************
	wire logic [NUM_OBJ-1:0] en_set;
	wire logic [NUM_OBJ-1:0] en_clr;
	wire logic [NUM_OBJ-1:0] im_set;
	wire logic [NUM_OBJ-1:0] im_clr;
	wire logic [NUM_OBJ-1:0] rx_clr;
	wire logic [NUM_OBJ-1:0] tx_clr;

	// ones only act
	// zero bits of the data gate every strobe, so zeros change nothing
	assign en_set = (wr_active && wa == `CMOB_OFS_ENABLE_SET)
		? wbits : '0;
	assign en_clr = (wr_active && wa == `CMOB_OFS_ENABLE_CLEAR)
		? wbits : '0;
	assign im_set = (wr_active && wa == `CMOB_OFS_IRQ_UNMASK)
		? wbits : '0;
	assign im_clr = (wr_active && wa == `CMOB_OFS_IRQ_MASK_CLEAR)
		? wbits : '0;
	assign rx_clr = (wr_active && wa == `CMOB_OFS_RX_DONE_CLEAR)
		? wbits : '0;
	assign tx_clr = (wr_active && wa == `CMOB_OFS_TX_DONE_CLEAR)
		? wbits : '0;

	// ****************************************
	// object vectors
	// ****************************************
	logic [NUM_OBJ-1:0] enabled;
	logic [NUM_OBJ-1:0] mask;
	logic [NUM_OBJ-1:0] rx_flag;
	logic [NUM_OBJ-1:0] tx_flag;

	wire logic [NUM_OBJ-1:0] next_enabled;
	wire logic [NUM_OBJ-1:0] next_mask;
	wire logic [NUM_OBJ-1:0] next_rx_flag;
	wire logic [NUM_OBJ-1:0] next_tx_flag;

	// set and clear update
	// set and clear of the same bit in one write cannot happen: separate
	// registers, so for enable and mask one strobe is always zero
	assign next_enabled = upd(enabled, en_set, en_clr);
	assign next_mask    = upd(mask, im_set, im_clr);
	assign next_rx_flag = upd(rx_flag, done_evt.rx_done[NUM_OBJ-1:0],
		rx_clr);
	assign next_tx_flag = upd(tx_flag, done_evt.tx_done[NUM_OBJ-1:0],
		tx_clr);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			enabled <= `CMOB_VEC_RESET;
			mask    <= `CMOB_VEC_RESET;
			rx_flag <= `CMOB_VEC_RESET;
			tx_flag <= `CMOB_VEC_RESET;
		end
		else
		begin
			enabled <= next_enabled;
			mask    <= next_mask;
			rx_flag <= next_rx_flag;
			tx_flag <= next_tx_flag;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	wire logic        rd_take;
	wire logic [31:0] next_rdata;

	assign rd_take = take_phase & ~hwrite;

	// state readback
	// read data is chosen in the address phase from the vectors as they
	// will stand, so a write just before a read is already visible
	assign next_rdata =
		(haddr[7:0] == `CMOB_OFS_ENABLE_STATE)   ? to_word(next_enabled) :
		(haddr[7:0] == `CMOB_OFS_IRQ_MASK_STATE) ? to_word(next_mask) :
		(haddr[7:0] == `CMOB_OFS_RX_DONE_STATE)  ? to_word(next_rx_flag) :
		(haddr[7:0] == `CMOB_OFS_TX_DONE_STATE)  ? to_word(next_tx_flag) :
		32'h0000_0000;

	// write-only and unmapped words read as zero
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (rd_take)
			hrdata <= next_rdata;
	end

	// zero wait states, response always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ****************************************
	// engine view and interrupt
	// ****************************************
	wire logic next_irq;

	assign next_irq = |((next_rx_flag | next_tx_flag) & next_mask);

	// duplicated flag storage
	// the per-object status views are separate flops loaded from the same next values as the vectors
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			obj_enabled        <= '0;
			per_object_rx_done <= '0;
			per_object_tx_done <= '0;
			irq                <= 1'b0;
		end
		else
		begin
			obj_enabled        <= next_enabled;
			per_object_rx_done <= next_rx_flag;
			per_object_tx_done <= next_tx_flag;
			irq                <= next_irq;
		end
	end

endmodule : cmob_bank

// ---- inc/cmob_defines.svh ----
// register offsets, reset values and bus encodings of the message object bank
`ifndef CMOB_DEFINES_SVH
`define CMOB_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CMOB_OFS_ENABLE_SET      8'h34
`define CMOB_OFS_ENABLE_CLEAR    8'h38
`define CMOB_OFS_ENABLE_STATE    8'h3c
`define CMOB_OFS_IRQ_UNMASK      8'h40
`define CMOB_OFS_IRQ_MASK_CLEAR  8'h44
`define CMOB_OFS_IRQ_MASK_STATE  8'h48
`define CMOB_OFS_RX_DONE_CLEAR   8'h4c
`define CMOB_OFS_RX_DONE_STATE   8'h50
`define CMOB_OFS_TX_DONE_CLEAR   8'h54
`define CMOB_OFS_TX_DONE_STATE   8'h58

// ****************************************
// reset values and bus encodings
// ****************************************
`define CMOB_VEC_RESET           32'h0000_0000
`define CMOB_HTRANS_NONSEQ       2'h2
`define CMOB_HTRANS_SEQ          2'h3

`endif

// ---- inc/cmob_pkg.sv ----
// types shared by the message object bank
package cmob_pkg;

	// ****************************************
	// captured bus address phase
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  addr;
	} cmob_addr_phase_t;

	// ****************************************
	// per-object completion reports from the engine
	// ****************************************
	typedef struct packed {
		logic [31:0] rx_done;
		logic [31:0] tx_done;
	} cmob_events_t;

endpackage : cmob_pkg

// ---- verif/cmob_engine_model.sv ----
// behavioural protocol engine that reports object completions
`timescale 1ns/1ps
module cmob_engine_model (
	input wire logic hclk,
	input wire logic go,
	input wire logic [31:0] rx,
	input wire logic [31:0] tx,
	output cmob_pkg::cmob_events_t done_evt
);
	// one-cycle pulse per request, quiet otherwise
	always_ff @(posedge hclk)
		done_evt <= go ? {rx, tx} : 64'h0;
endmodule : cmob_engine_model

// ---- verif/cmob_bank_properties.sv ----
// assertions on the message object bank ports
`timescale 1ns/1ps
module cmob_bank_properties #(parameter int NUM_OBJ = 32) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire cmob_pkg::cmob_events_t done_evt,
	input wire logic [NUM_OBJ-1:0] obj_enabled,
	input wire logic [NUM_OBJ-1:0] per_object_rx_done,
	input wire logic [NUM_OBJ-1:0] per_object_tx_done,
	input wire logic irq
);
	logic d_wr;
	logic [7:0] d_a;
	wire take = hsel && hready && htrans[1];
	// remember a write address phase for its data phase
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			d_wr <= 1'b0;
		else
			d_wr <= take && hwrite;
	always_ff @(posedge hclk)
		d_a <= haddr[7:0];
	wire ws = d_wr && d_a == 8'h34;
	wire wc = d_wr && d_a == 8'h38;
	wire wrx = d_wr && d_a == 8'h4c;
	wire wtx = d_wr && d_a == 8'h54;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	en_set_a: assert property (ws |=> obj_enabled ==
		($past(obj_enabled) | $past(hwdata))) else $error("enable set");
	en_clr_a: assert property (wc |=> obj_enabled ==
		($past(obj_enabled) & ~$past(hwdata))) else $error("enable clear");
	en_hold_a: assert property (!ws && !wc |=> $stable(obj_enabled))
		else $error("enable moved without write");
	en_read_a: assert property (take && !hwrite && haddr[7:0] == 8'h3c
		|=> hrdata == obj_enabled) else $error("enable state read");
	rx_set_a: assert property (done_evt.rx_done != 0 |=>
		(per_object_rx_done & $past(done_evt.rx_done)) ==
		$past(done_evt.rx_done)) else $error("rx flag not set");
	rx_clr_a: assert property (wrx |=> per_object_rx_done ==
		(($past(per_object_rx_done) & ~$past(hwdata)) |
		$past(done_evt.rx_done))) else $error("rx clear");
	rx_hold_a: assert property (!wrx && done_evt.rx_done == 0
		|=> $stable(per_object_rx_done)) else $error("rx flag moved");
	tx_set_a: assert property (done_evt.tx_done != 0 |=>
		(per_object_tx_done & $past(done_evt.tx_done)) ==
		$past(done_evt.tx_done)) else $error("tx flag not set");
	tx_clr_a: assert property (wtx |=> per_object_tx_done ==
		(($past(per_object_tx_done) & ~$past(hwdata)) |
		$past(done_evt.tx_done))) else $error("tx clear");
	irq_src_a: assert property (irq |->
		(per_object_rx_done | per_object_tx_done) != 0)
		else $error("irq without flag");
	cover property (irq);
	cover property (wrx);
	cover property (ws);
endmodule : cmob_bank_properties
bind cmob_bank cmob_bank_properties #(.NUM_OBJ(NUM_OBJ)) chk (.*);

// ---- verif/cmob_bank_bench.sv ----
// self-checking bench for the message object bank
`timescale 1ns/1ps
module cmob_bank_bench;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0;
	logic [31:0] haddr = '0, hwdata = '0, rx = '0, tx = '0, r;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	wire hready, hreadyout, hresp, irq;
	wire [31:0] hrdata, obj_enabled, per_object_rx_done, per_object_tx_done;
	cmob_pkg::cmob_events_t done_evt;
	int mismatches = 0, cmp_count = 0;
	logic [7:0] ra [4] = '{8'h3c, 8'h48, 8'h50, 8'h58};
	// rows: write offset, data, read offset, expected word
	logic [79:0] rows [9] = '{
		{8'h34, 32'hf0f0_0001, 8'h3c, 32'hf0f0_0001},
		{8'h34, 32'h0, 8'h3c, 32'hf0f0_0001},
		{8'h38, 32'h8000_0001, 8'h3c, 32'h70f0_0000},
		{8'h40, 32'hff, 8'h48, 32'hff},
		{8'h44, 32'hf, 8'h48, 32'hf0},
		{8'h44, 32'h0, 8'h48, 32'hf0},
		{8'h30, 32'hffff_ffff, 8'h30, 32'h0},
		{8'h38, 32'h0, 8'h34, 32'h0},
		{8'h38, 32'hffff_ffff, 8'h3c, 32'h0}};
	assign hready = hreadyout;
	cmob_bank uut (.*);
	cmob_engine_model eng (.*);
	initial forever #2 hclk = ~hclk;
	task finish_test;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// bounded wait for hready, a hang counts as a mismatch
	task rdy;
		int n;
		n = 0;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 16);
		mismatches += (n == 16);
		if (n == 16) finish_test();
	endtask : rdy
	// single word transfer; read data taken at the data phase edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask : xfer
	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(r, e);
	endtask : rd
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (ra[i]) rd(ra[i], 32'h0);
		foreach (rows[i])
		begin
			xfer(1'b1, rows[i][79:72], rows[i][71:40]);
			rd(rows[i][39:32], rows[i][31:0]);
		end
		// engine reports two receptions and one transmission
		rx <= 32'h11;
		tx <= 32'h8000_0000;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		repeat (2) @(posedge hclk);
		rd(8'h50, 32'h11);
		chk(per_object_rx_done, 32'h11);
		chk({31'h0, irq}, 32'h1);
		rd(8'h58, 32'h8000_0000);
		chk(per_object_tx_done, 32'h8000_0000);
		chk({31'h0, hresp}, 32'h0);
		xfer(1'b1, 8'h4c, 32'h10);
		rd(8'h50, 32'h1);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, 8'h54, 32'h8000_0000);
		rd(8'h58, 32'h0);
		chk(per_object_tx_done, 32'h0);
		xfer(1'b1, 8'h34, 32'h5);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		chk(obj_enabled, 32'h0);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(8'h3c, 32'h0);
		rd(8'h48, 32'h0);
		chk({31'h0, irq}, 32'h0);
		finish_test();
	end
endmodule : cmob_bank_bench
